// >>> verilog/ilvm_core.sv
// Interrupt latch and vector map with an Avalon-MM register slave.
//
// Implementation choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module ilvm_core #(
  parameter int N = ilvm_pkg::NUM_MASKABLE
) (
  // Clock and reset.
  input  wire logic                 clk_i,
  input  wire logic                 srst_i,
  // Mode: high while in a special test mode.
  input  wire logic                 special_mode_i,
  // External request pins, active low.
  input  wire logic                 nonmaskable_ext_request_n_i,
  input  wire logic                 ext_request_n_i,
  // Peripheral flags ANDed with local enables, index 1 upward (index 0 is the pin).
  input  wire logic [N-1:0]         periph_req_i,
  // Core side.
  input  wire logic                 software_trap_instruction_i,
  input  wire logic                 illegal_op_i,
  input  wire logic                 service_ack_i,
  output ilvm_pkg::ilvm_vec_t       vec_o,
  output logic                      i_mask_o,
  output logic                      x_mask_o,
  // Avalon-MM slave.
  input  wire logic [1:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  output logic [31:0]               avs_readdata,
  output logic                      avs_waitrequest
);
  // Refuse a source count that differs from the fixed vector map.
  if (N != ilvm_pkg::NUM_MASKABLE) begin : g_bad_count
    $error("ilvm_core: source count must match the vector map");
  end

  // ****************************************
  // Registers
  // ****************************************
  logic       edge_sel_r;
  logic       edge_written_r;
  logic       connect_r;
  logic [7:0] top_priority_select_r;
  logic       i_mask_r;
  logic       x_mask_r;
  logic       edge_latch_r;
  logic       ext_prev_r;
  logic       ack_wait_r;
  logic [7:0] serviced_low_r;
  logic [31:0] rdata_r;

  logic       wr_ctrl;
  logic       wr_prio;
  logic       wr_mask;
  logic [N-1:0] pend;
  logic       hit;
  logic [7:0] sel_low;
  logic       ext_level;
  logic       ext_fall;

  // Writes land only at the edge where waitrequest is seen low by the master.
  assign wr_ctrl = avs_write && ack_wait_r && avs_address == ilvm_pkg::ADDR_CTRL;
  assign wr_prio = avs_write && ack_wait_r && avs_address == ilvm_pkg::ADDR_PRIO;
  assign wr_mask = avs_write && ack_wait_r && avs_address == ilvm_pkg::ADDR_MASK;

  // Every access waits one cycle, then completes.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ack_wait_r <= 1'b0;
    end else begin
      ack_wait_r <= (avs_read || avs_write) && !ack_wait_r;
    end
  end
  assign avs_waitrequest = (avs_read || avs_write) && !ack_wait_r;
  assign avs_readdata    = rdata_r;

  // Edge select is write-once in normal mode; special mode ignores the first write.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      edge_sel_r     <= ilvm_pkg::CTRL_RESET[ilvm_pkg::CTRL_EDGE_BIT];
      connect_r      <= ilvm_pkg::CTRL_RESET[ilvm_pkg::CTRL_CONNECT_BIT];
      edge_written_r <= 1'b0;
    end else if (wr_ctrl) begin
      edge_written_r <= 1'b1;
      connect_r      <= avs_writedata[ilvm_pkg::CTRL_CONNECT_BIT];
      if (!edge_written_r ^ special_mode_i) begin
        edge_sel_r <= avs_writedata[ilvm_pkg::CTRL_EDGE_BIT];
      end
    end
  end

  // Priority select written only while I is set.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      top_priority_select_r <= ilvm_pkg::PRIO_RESET;
    end else if (wr_prio && i_mask_r) begin
      top_priority_select_r <= avs_writedata[7:0];
    end
  end

  // Global masks: I resets set; X may only be cleared by software.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      i_mask_r <= ilvm_pkg::MASK_RESET[ilvm_pkg::MASK_I_BIT];
      x_mask_r <= ilvm_pkg::MASK_RESET[ilvm_pkg::MASK_X_BIT];
    end else if (wr_mask) begin
      i_mask_r <= avs_writedata[ilvm_pkg::MASK_I_BIT];
      x_mask_r <= x_mask_r & avs_writedata[ilvm_pkg::MASK_X_BIT];
    end
  end
  assign i_mask_o = i_mask_r;
  assign x_mask_o = x_mask_r;

  // Read data register.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rdata_r <= 32'h0000_0000;
    end else if (avs_read && !ack_wait_r) begin
      case (avs_address)
        ilvm_pkg::ADDR_CTRL: rdata_r <= {24'h0, edge_sel_r, connect_r, 6'h00};
        ilvm_pkg::ADDR_PRIO: rdata_r <= {24'h0, top_priority_select_r};
        ilvm_pkg::ADDR_MASK: rdata_r <= {30'h0, x_mask_r, i_mask_r};
        ilvm_pkg::ADDR_STAT: rdata_r <= {14'h0, vec_o.valid, vec_o.vector, edge_latch_r};
        default:             rdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // External request latching
  // ****************************************
  assign ext_level = connect_r && !ext_request_n_i;
  assign ext_fall  = connect_r && ext_prev_r && !ext_request_n_i;

  // Falling-edge latch holds until the pin's vector is serviced.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ext_prev_r   <= 1'b1;
      edge_latch_r <= 1'b0;
    end else begin
      ext_prev_r <= ext_request_n_i;
      if (edge_sel_r && ext_fall) begin
        edge_latch_r <= 1'b1;
      end else if (service_ack_i && vec_o.vector[7:0] == ilvm_pkg::VEC_TOP_LOW) begin
        edge_latch_r <= 1'b0;
      end
    end
  end

  // Pending maskable sources; peripheral flags are held by the peripherals.
  always_comb begin
    pend    = periph_req_i & {N{!i_mask_r}};
    pend[0] = !i_mask_r && (edge_sel_r ? edge_latch_r : ext_level);
  end

  ilvm_prio_enc #(.N(N)) u_enc (
    .pend_i (pend),
    .elev_i (top_priority_select_r),
    .hit_o  (hit),
    .low_o  (sel_low)
  );

  // Vector selection; nonmaskable request uses only X.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      vec_o          <= '{valid: 1'b1, vector: {ilvm_pkg::VEC_HIGH, ilvm_pkg::VEC_RESET_LOW}};
      serviced_low_r <= ilvm_pkg::VEC_RESET_LOW;
    end else begin
      vec_o.valid <= 1'b1;
      if (illegal_op_i) begin
        vec_o.vector <= {ilvm_pkg::VEC_HIGH, ilvm_pkg::VEC_TRAP_LOW};
      end else if (software_trap_instruction_i) begin
        vec_o.vector <= {ilvm_pkg::VEC_HIGH, ilvm_pkg::VEC_SWT_LOW};
      end else if (!x_mask_r && !nonmaskable_ext_request_n_i) begin
        vec_o.vector <= {ilvm_pkg::VEC_HIGH, ilvm_pkg::VEC_XREQ_LOW};
      end else if (hit) begin
        vec_o.vector <= {ilvm_pkg::VEC_HIGH, sel_low};
      end else begin
        vec_o.vector <= {ilvm_pkg::VEC_HIGH, ilvm_pkg::VEC_TRAP_LOW};
        vec_o.valid  <= 1'b0;
      end
      if (service_ack_i) begin
        serviced_low_r <= vec_o.vector[7:0];
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  prio_write_gate_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (wr_prio && !i_mask_r) |=> $stable(top_priority_select_r))
    else $error("Priority select changed while I clear.");
  i_reset_set_a: assert property (@(posedge clk_i)
    srst_i |=> i_mask_r)
    else $error("I mask not set after reset.");
  edge_hold_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (edge_latch_r && !service_ack_i) |=> edge_latch_r)
    else $error("Edge latch lost before service.");
  masked_idle_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (i_mask_r && x_mask_r && !illegal_op_i && !software_trap_instruction_i)
    |=> vec_o.vector[7:0] == ilvm_pkg::VEC_TRAP_LOW)
    else $error("Masked source reached the core.");
  xreq_vector_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (!x_mask_r && !nonmaskable_ext_request_n_i && !illegal_op_i
     && !software_trap_instruction_i) |=> vec_o.vector[7:0] == ilvm_pkg::VEC_XREQ_LOW)
    else $error("Nonmaskable request vector wrong.");
  empty_trap_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (pend == '0 && !illegal_op_i && !software_trap_instruction_i
     && (x_mask_r || nonmaskable_ext_request_n_i))
    |=> !vec_o.valid && vec_o.vector == {ilvm_pkg::VEC_HIGH, ilvm_pkg::VEC_TRAP_LOW})
    else $error("No source but not trap vector.");
  modcnt_vec_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (pend == N'(1) << 19 && (x_mask_r || nonmaskable_ext_request_n_i)
     && !illegal_op_i && !software_trap_instruction_i)
    |=> vec_o.vector[7:0] == ilvm_pkg::VEC_MODCNT)
    else $error("Down counter vector wrong.");
  level_pin_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (!edge_sel_r && !i_mask_r && connect_r && !ext_request_n_i) |-> pend[0])
    else $error("Level request not pending.");
  edge_once_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (wr_ctrl && edge_written_r && !special_mode_i) |=> $stable(edge_sel_r))
    else $error("Edge select rewritten.");

  // A qualified falling edge always sets the latch, even against a clear.
  edge_set_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (edge_sel_r && ext_fall) |=> edge_latch_r)
    else $error("Falling edge not latched.");

  // Servicing the pin vector empties the latch with no software write.
  edge_clear_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (service_ack_i && vec_o.vector[7:0] == ilvm_pkg::VEC_TOP_LOW && !(edge_sel_r && ext_fall))
    |=> !edge_latch_r)
    else $error("Edge latch kept after service.");

  // The nonmaskable pin has no memory: a released pin never gives its vector.
  nmi_level_a: assert property (@(posedge clk_i) disable iff (srst_i)
    nonmaskable_ext_request_n_i |=> vec_o.vector[7:0] != ilvm_pkg::VEC_XREQ_LOW)
    else $error("Nonmaskable vector without a low pin.");

  // The X mask alone blocks the nonmaskable request.
  x_gate_a: assert property (@(posedge clk_i) disable iff (srst_i)
    x_mask_r |=> vec_o.vector[7:0] != ilvm_pkg::VEC_XREQ_LOW)
    else $error("Nonmaskable vector while X set.");

  // Once cleared, X stays clear until reset.
  x_no_set_a: assert property (@(posedge clk_i) disable iff (srst_i)
    !x_mask_r |=> !x_mask_r)
    else $error("X mask set again by software.");

  // The unimplemented instruction trap outranks everything else.
  trap_first_a: assert property (@(posedge clk_i) disable iff (srst_i)
    illegal_op_i
    |=> vec_o.valid && vec_o.vector == {ilvm_pkg::VEC_HIGH, ilvm_pkg::VEC_TRAP_LOW})
    else $error("Trap vector not presented.");

  // The software trap comes next in line.
  swt_vector_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (software_trap_instruction_i && !illegal_op_i)
    |=> vec_o.vector == {ilvm_pkg::VEC_HIGH, ilvm_pkg::VEC_SWT_LOW})
    else $error("Software trap vector wrong.");

  // A set I mask leaves no maskable source pending.
  i_gate_a: assert property (@(posedge clk_i) disable iff (srst_i)
    i_mask_r |-> pend == '0)
    else $error("Maskable source pending while I set.");

  // Software may clear or set I through the mask register.
  mask_write_a: assert property (@(posedge clk_i) disable iff (srst_i)
    wr_mask |=> i_mask_r == $past(avs_writedata[ilvm_pkg::MASK_I_BIT]))
    else $error("I mask write lost.");

  // A priority write while masked is taken as written.
  prio_take_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (wr_prio && i_mask_r) |=> top_priority_select_r == $past(avs_writedata[7:0]))
    else $error("Priority select write lost.");

  // In level mode a released or disconnected pin is not pending.
  level_clear_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (!edge_sel_r && (ext_request_n_i || !connect_r)) |-> !pend[0])
    else $error("Released level pin still pending.");

  // In edge mode only the latch makes the pin pending.
  edge_mode_a: assert property (@(posedge clk_i) disable iff (srst_i)
    edge_sel_r |-> pend[0] == (!i_mask_r && edge_latch_r))
    else $error("Edge mode pending does not follow latch.");

  // The chosen maskable source is what the core sees one cycle later.
  sel_present_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (hit && !illegal_op_i && !software_trap_instruction_i
     && (x_mask_r || nonmaskable_ext_request_n_i))
    |=> vec_o.valid && vec_o.vector[7:0] == $past(sel_low))
    else $error("Selected source not presented.");

  // Main scenarios that the bench should reach.
  prio_write_c: cover property (@(posedge clk_i) wr_prio && i_mask_r);
  edge_svc_c:   cover property (@(posedge clk_i) edge_latch_r ##1 !edge_latch_r);
  trap_c:       cover property (@(posedge clk_i) !vec_o.valid);
  nmi_c:        cover property (@(posedge clk_i) !x_mask_r && !nonmaskable_ext_request_n_i);
  elev_c:       cover property (@(posedge clk_i) hit && sel_low == top_priority_select_r);
endmodule
`default_nettype wire

// >>> verilog/ilvm_pkg.sv
// Package with constants and types for the interrupt latch and vector map block.
package ilvm_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [1:0] ADDR_CTRL  = 2'h0;
  localparam logic [1:0] ADDR_PRIO  = 2'h1;
  localparam logic [1:0] ADDR_MASK  = 2'h2;
  localparam logic [1:0] ADDR_STAT  = 2'h3;

  // Control and mask register field positions.
  localparam int CTRL_EDGE_BIT    = 7;
  localparam int CTRL_CONNECT_BIT = 6;
  localparam int MASK_I_BIT       = 0;
  localparam int MASK_X_BIT       = 1;

  // Reset values.
  localparam logic [7:0] CTRL_RESET = 8'h40;
  localparam logic [7:0] PRIO_RESET = 8'hF2;
  localparam logic [1:0] MASK_RESET = 2'h3;

  // ****************************************
  // Vector constants
  // ****************************************
  localparam int         NUM_MASKABLE  = 34;
  localparam logic [7:0] VEC_TOP_LOW   = 8'hF2;
  localparam logic [7:0] VEC_BOTTOM_LOW= 8'hB0;
  localparam logic [7:0] VEC_XREQ_LOW  = 8'hF4;
  localparam logic [7:0] VEC_SWT_LOW   = 8'hF6;
  localparam logic [7:0] VEC_TRAP_LOW  = 8'hF8;
  localparam logic [7:0] VEC_RESET_LOW = 8'hFE;
  localparam logic [7:0] VEC_HIGH      = 8'hFF;
  localparam logic [7:0] VEC_MODCNT    = 8'hCC;
  localparam logic [7:0] VEC_PACC_EDGE = 8'hDA;
  localparam logic [7:0] VEC_SPI_DONE  = 8'hD8;
  localparam logic [7:0] VEC_CLK_EVENT = 8'hC2;
  localparam logic [7:0] VEC_PACCB_OVF = 8'hCA;

  // Core handshake toward the processor.
  typedef struct packed {
    logic        valid;
    logic [15:0] vector;
  } ilvm_vec_t;

endpackage

// >>> verilog/ilvm_prio_enc.sv
// Priority encoder that picks the elevated or highest-address pending source.
`timescale 1ns/1ps
`default_nettype none
module ilvm_prio_enc #(
  parameter int N = 34
) (
  // Pending request vector, bit 0 is the highest vector address.
  input  wire logic [N-1:0] pend_i,
  input  wire logic [7:0]   elev_i,
  // Selected source.
  output logic              hit_o,
  output logic [7:0]        low_o
);
  // Refuse source counts that the scan loops and the 8-bit codes cannot serve.
  if (N < 1 || N > 64) begin : g_bad_count
    $error("ilvm_prio_enc: unsupported source count");
  end

  // Scan from lowest priority so the highest ends up winning.
  always_comb begin
    hit_o = 1'b0;
    low_o = ilvm_pkg::VEC_TOP_LOW;
    for (int k = N - 1; k >= 0; k--) begin
      if (pend_i[k]) begin
        hit_o = 1'b1;
        low_o = 8'(ilvm_pkg::VEC_TOP_LOW - 8'(2 * k));
      end
    end
    for (int k = 0; k < N; k++) begin
      if (pend_i[k] && elev_i == 8'(ilvm_pkg::VEC_TOP_LOW - 8'(2 * k))) begin
        low_o = elev_i;
      end
    end
  end
endmodule
`default_nettype wire

// >>> dv/ilvm_core_model.sv
// Partner model of the core service handshake and an external request source.
`timescale 1ns/1ps
`default_nettype none
module ilvm_core_model (
  // Clock and reset.
  input  wire logic                clk_i,
  input  wire logic                srst_i,
  // Commands from the bench.
  input  wire logic                raise_i,
  input  wire logic                keep_i,
  input  wire logic                serve_i,
  // Device side.
  input  wire ilvm_pkg::ilvm_vec_t vec_i,
  output logic                     req_n_o,
  output logic                     ack_o
);
  logic [1:0] age_r;

  // The core services one presented vector for each serve command.
  always_ff @(posedge clk_i) begin
    ack_o <= serve_i & vec_i.valid & ~ack_o & ~srst_i;
  end

  // The source holds a level request until serviced, or gives a short low pulse.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      req_n_o <= 1'b1;
      age_r   <= 2'h0;
    end else if (raise_i) begin
      req_n_o <= 1'b0;
      age_r   <= 2'h0;
    end else if (!req_n_o) begin
      age_r <= age_r + 2'h1;
      if ((keep_i && ack_o) || (!keep_i && age_r == 2'h3)) begin
        req_n_o <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> dv/tb.sv
// Self-checking testbench for the interrupt latch and vector map block.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic                clk_i, srst_i, nmi_n, swt, raise, keep, serve, ack, req_n;
  logic                spec, ill;
  logic                i_mask, x_mask, avs_read, avs_write, avs_waitrequest;
  logic [33:0]         periph;
  logic [1:0]          avs_address;
  logic [31:0]         avs_writedata, avs_readdata;
  logic [7:0]          q;
  ilvm_pkg::ilvm_vec_t vec;
  int                  bad_count = 0;
  int                  checked = 0;
  int                  cyc = 0;

  // ****************************************
  // Design, partner and clock
  // ****************************************
  ilvm_core dut (.clk_i(clk_i), .srst_i(srst_i), .special_mode_i(spec),
    .nonmaskable_ext_request_n_i(nmi_n), .ext_request_n_i(req_n),
    .periph_req_i(periph), .software_trap_instruction_i(swt), .illegal_op_i(ill),
    .service_ack_i(ack), .vec_o(vec), .i_mask_o(i_mask), .x_mask_o(x_mask),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  ilvm_core_model core (.clk_i(clk_i), .srst_i(srst_i), .raise_i(raise), .keep_i(keep),
    .serve_i(serve), .vec_i(vec), .req_n_o(req_n), .ack_o(ack));

  // A 100 ns clock.
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // A hung run is cut short and counted as a mismatch.
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      wrap_up();
    end
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  // Waits a number of clock edges.
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Compares a register byte.
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Compares the presented vector with its valid flag.
  task automatic vchk(input logic [16:0] exp);
    checked++;
    if (vec !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, vec, exp);
    end
  endtask

  // One bus transfer, held until waitrequest is seen low at an edge.
  task automatic bus(input logic [1:0] a, input logic w, input logic [7:0] d);
    avs_address   <= a;
    avs_write     <= w;
    avs_read      <= ~w;
    avs_writedata <= {24'h0, d};
    @(posedge clk_i iff avs_waitrequest === 1'b0);
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge clk_i);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  // Elevation is taken while masked, refused once unmasked.
  task automatic t_prio();
    bus(ilvm_pkg::ADDR_PRIO, 1'b1, 8'hCC);
    bus(ilvm_pkg::ADDR_MASK, 1'b1, 8'h00);
    cmp({6'h0, x_mask, i_mask}, 8'h00);
    bus(ilvm_pkg::ADDR_PRIO, 1'b1, 8'hDA);
    bus(ilvm_pkg::ADDR_PRIO, 1'b0, 8'h00);
    cmp(q, 8'hCC);
    periph[12] <= 1'b1;
    periph[19] <= 1'b1;
    tick(3);
    vchk({1'b1, 16'hFFCC});
    periph[19] <= 1'b0;
    periph[13] <= 1'b1;
    tick(3);
    vchk({1'b1, 16'hFFDA});
    periph <= 34'h0;
    tick(3);
    vchk({1'b0, 16'hFFF8});
  endtask

  // Six single peripheral sources each map to their own vector.
  task automatic t_map();
    int         k[6] = '{19, 12, 13, 24, 20, 33};
    logic [7:0] e[6] = '{ilvm_pkg::VEC_MODCNT, ilvm_pkg::VEC_PACC_EDGE, ilvm_pkg::VEC_SPI_DONE,
                         ilvm_pkg::VEC_CLK_EVENT, ilvm_pkg::VEC_PACCB_OVF,
                         ilvm_pkg::VEC_BOTTOM_LOW};
    for (int i = 0; i < 6; i++) begin
      periph <= 34'h1 << k[i];
      tick(3);
      vchk({1'b1, ilvm_pkg::VEC_HIGH, e[i]});
    end
    periph <= 34'h0;
    tick(3);
  endtask

  // A level request stays until serviced, then nothing is pending.
  task automatic t_level();
    keep  <= 1'b1;
    raise <= 1'b1;
    tick(1);
    raise <= 1'b0;
    tick(3);
    vchk({1'b1, 16'hFFF2});
    serve <= 1'b1;
    tick(1);
    serve <= 1'b0;
    tick(4);
    vchk({1'b0, 16'hFFF8});
  endtask

  // Nonmaskable pin and trap instruction vectors.
  task automatic t_nmi();
    nmi_n <= 1'b0;
    tick(3);
    vchk({1'b1, 16'hFFF4});
    swt <= 1'b1;
    tick(3);
    vchk({1'b1, 16'hFFF6});
    ill <= 1'b1;
    tick(3);
    vchk({1'b1, 16'hFFF8});
    ill   <= 1'b0;
    swt   <= 1'b0;
    nmi_n <= 1'b1;
    tick(3);
  endtask

  // A short falling pulse is held until serviced; edge select locks.
  task automatic t_edge();
    bus(ilvm_pkg::ADDR_CTRL, 1'b1, 8'hC0);
    keep  <= 1'b0;
    raise <= 1'b1;
    tick(1);
    raise <= 1'b0;
    tick(8);
    vchk({1'b1, 16'hFFF2});
    serve <= 1'b1;
    tick(1);
    serve <= 1'b0;
    tick(4);
    vchk({1'b0, 16'hFFF8});
    bus(ilvm_pkg::ADDR_CTRL, 1'b1, 8'h40);
    bus(ilvm_pkg::ADDR_CTRL, 1'b0, 8'h00);
    cmp(q, 8'hC0);
  endtask

  // A fresh reset in special mode: the first edge select write is dropped, the next lands.
  task automatic t_special();
    spec   <= 1'b1;
    srst_i <= 1'b1;
    tick(2);
    srst_i <= 1'b0;
    vchk({1'b1, 16'hFFFE});
    cmp({6'h0, x_mask, i_mask}, 8'h03);
    bus(ilvm_pkg::ADDR_CTRL, 1'b1, 8'hC0);
    bus(ilvm_pkg::ADDR_CTRL, 1'b0, 8'h00);
    cmp(q, ilvm_pkg::CTRL_RESET);
    bus(ilvm_pkg::ADDR_CTRL, 1'b1, 8'hC0);
    bus(ilvm_pkg::ADDR_CTRL, 1'b0, 8'h00);
    cmp(q, 8'hC0);
    spec <= 1'b0;
  endtask

  // Reset, then the scenarios in turn.
  initial begin
    {srst_i, nmi_n} = 2'b11;
    {swt, ill, spec, raise, keep, serve, avs_read, avs_write} = 8'h00;
    periph        = 34'h0;
    avs_address   = 2'h0;
    avs_writedata = 32'h0;
    tick(16);
    srst_i <= 1'b0;
    vchk({1'b1, 16'hFFFE});
    cmp({7'h0, i_mask}, 8'h01);
    bus(ilvm_pkg::ADDR_CTRL, 1'b0, 8'h00);
    cmp(q, ilvm_pkg::CTRL_RESET);
    t_prio();
    t_map();
    t_level();
    t_nmi();
    t_edge();
    t_special();
    wrap_up();
  end
endmodule
`default_nettype wire
